// ===== hdl/mrsx_defines.vh
// constants for the rotate / subtract / skip execution datapath
// Notes on behaviour
// [RULE1] left rotate via carry, working form keeps memory
// [RULE2] plain right rotate, bit 0 to 7, no flags
// [RULE3] right rotate into working, memory and flags kept
// [RULE4] right rotate via carry, only carry changes
// [RULE5] working form: old carry bit 7, bit0 to carry
// [RULE6] working minus memory minus inverted carry, all flags
// [RULE7] borrow subtract result into memory byte instead
// [RULE8] decrement memory, skip when zero, no flags
// [RULE9] working forms of dec/inc skip keep memory
// [RULE10] increment memory, skip when zero, no flags
// [RULE11] taken skip adds one dummy instruction cycle
// [RULE12] set byte writes all ones, no flags
// [RULE13] set bit forces one selected bit only
// [RULE14] skip next when selected bit is one
// [RULE15] subtract memory or immediate into working, all flags
// [RULE16] subtract result stored back into memory byte
// [RULE17] nibble swap, working form keeps memory, no flags
// [RULE18] skip when whole byte zero, nothing modified
// [RULE19] copy byte to working, skip when zero
// [RULE20] skip next when selected bit is zero
// [RULE21] table fetch low to memory, high to latch
// [RULE22] exclusive-or into working or memory, zero flag
`ifndef MRSX_DEFINES_VH
`define MRSX_DEFINES_VH

`define MRSX_OP_W           5
`define MRSX_OP_RLC         5'h00
`define MRSX_OP_ROTATE_LEFT_VIA_FLAG_TO_WORKING        5'h01
`define MRSX_OP_RR          5'h02
`define MRSX_OP_RRA         5'h03
`define MRSX_OP_RRC         5'h04
`define MRSX_OP_ROTATE_RIGHT_VIA_FLAG_TO_WORKING        5'h05
`define MRSX_OP_SBC         5'h06
`define MRSX_OP_MINUS_WITH_BORROW_TO_MEMORY        5'h07
`define MRSX_OP_SDZ         5'h08
`define MRSX_OP_DECREMENT_SKIP_ZERO_TO_WORKING        5'h09
`define MRSX_OP_SIZ         5'h0A
`define MRSX_OP_INCREMENT_SKIP_ZERO_TO_WORKING        5'h0B
`define MRSX_OP_SETB        5'h0C
`define MRSX_OP_SETBIT      5'h0D
`define MRSX_OP_SNZ         5'h0E
`define MRSX_OP_SUB         5'h0F
`define MRSX_OP_SUBI        5'h10
`define MRSX_OP_MINUS_INTO_MEMORY        5'h11
`define MRSX_OP_SWAP        5'h12
`define MRSX_OP_NIBBLE_EXCHANGE_TO_WORKING       5'h13
`define MRSX_OP_SZ          5'h14
`define MRSX_OP_SZA         5'h15
`define MRSX_OP_SZBIT       5'h16
`define MRSX_OP_TABC        5'h17
`define MRSX_OP_TABL        5'h18
`define MRSX_OP_XOR         5'h19
`define MRSX_OP_XORI        5'h1A
`define MRSX_OP_EXCLUSIVE_OR_INTO_MEMORY        5'h1B

`define MRSX_ZERO8          8'h00
`define MRSX_ONES8          8'hFF
`define MRSX_ONE8           8'h01
`define MRSX_MSB            7
`define MRSX_NIB            4

`define MRSX_ST_IDLE        3'h1
`define MRSX_ST_EXEC        3'h2
`define MRSX_ST_DUMMY       3'h4

`endif

// ===== hdl/mrsx_subtractor.v
// 8-bit subtractor with borrow-in and flag outputs
`include "mrsx_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module mrsx_subtractor #(
    parameter W = 8
) (
    // operands
    input  wire [W-1:0] minuend_in,
    input  wire [W-1:0] subtrahend_in,
    input  wire         carry_in,
    // result and flags
    output wire [W-1:0] diff_out,
    output wire         carry_out,
    output wire         half_out,
    output wire         wrap_out,
    output wire         zero_out
);
    // carry is a not-borrow: add the complement plus carry
    wire [W:0]   full_sum;
    wire [`MRSX_NIB:0] low_sum;
    assign full_sum  = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + {{W{1'b0}}, carry_in};
    assign low_sum   = {1'b0, minuend_in[`MRSX_NIB-1:0]} + {1'b0, ~subtrahend_in[`MRSX_NIB-1:0]}
                     + {{`MRSX_NIB{1'b0}}, carry_in};
    assign diff_out  = full_sum[W-1:0];
    assign carry_out = full_sum[W];
    assign half_out  = low_sum[`MRSX_NIB];
    assign wrap_out  = (minuend_in[W-1] ^ subtrahend_in[W-1]) & (minuend_in[W-1] ^ full_sum[W-1]);
    assign zero_out  = (full_sum[W-1:0] == {W{1'b0}});
endmodule
`default_nettype wire

// ===== hdl/mrsx_exec.v
// execution datapath for rotate, subtract, skip, set, swap, table read and xor
`include "mrsx_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module mrsx_exec #(
    parameter DW = 8,
    parameter PW = 15,
    parameter AW = 10
) (
    // clock and reset
    input  wire          CLOCK_IN,
    input  wire          RST_IN,
    input  wire          CE_IN,
    // instruction issue
    input  wire          START_IN,
    input  wire [4:0]    OPCODE_IN,
    input  wire [2:0]    BIT_SEL_IN,
    input  wire [DW-1:0] IMM_IN,
    input  wire [DW-1:0] MEM_RDATA_IN,
    // table pointer and program code
    input  wire [DW-1:0] TABLE_POINTER_IN,
    input  wire [AW-1:0] PC_IN,
    input  wire [PW-1:0] CODE_RDATA_IN,
    output reg  [AW-1:0] CODE_ADDR_OUT,
    // data memory write
    output reg           MEM_WE_OUT,
    output reg  [DW-1:0] MEM_WDATA_OUT,
    // working register and flags
    output reg  [DW-1:0] WORKING_OUT,
    output reg           CARRY_FLAG_OUT,
    output reg           ZERO_FLAG_OUT,
    output reg           SIGNED_WRAP_FLAG_OUT,
    output reg           HALF_CARRY_FLAG_OUT,
    output reg  [PW-DW-1:0] TABLE_HIGH_LATCH_OUT,
    // sequencing
    output reg           DONE_OUT,
    output reg           SKIP_OUT,
    output reg           DUMMY_CYCLE_OUT,
    output reg           BUSY_OUT
);
    // ----------------------------------------
    // state and latched instruction
    // ----------------------------------------
    reg [2:0]    state_ff;
    reg [2:0]    nxt_state;
    reg [4:0]    op_ff;
    reg [2:0]    bit_ff;
    reg [DW-1:0] imm_ff;

    // ----------------------------------------
    // subtract unit
    // ----------------------------------------
    // one adder serves all five subtract forms; the plain forms force
    // the carry-in high so that no borrow is taken in
    wire          is_borrow_op;
    wire [DW-1:0] sub_rhs;
    wire [DW-1:0] sub_diff;
    wire          sub_c;
    wire          sub_h;
    wire          sub_v;
    wire          sub_z;
    assign is_borrow_op = (op_ff == `MRSX_OP_SBC) || (op_ff == `MRSX_OP_MINUS_WITH_BORROW_TO_MEMORY);
    assign sub_rhs      = (op_ff == `MRSX_OP_SUBI) ? imm_ff : MEM_RDATA_IN;

    mrsx_subtractor #(
        .W (DW)
    ) u_sub (
        .minuend_in    (WORKING_OUT),
        .subtrahend_in (sub_rhs),
        .carry_in      (is_borrow_op ? CARRY_FLAG_OUT : 1'b1), // RULE6
        .diff_out      (sub_diff),
        .carry_out     (sub_c),
        .half_out      (sub_h),
        .wrap_out      (sub_v),
        .zero_out      (sub_z)
    );

    // ----------------------------------------
    // combinational result
    // ----------------------------------------
    reg [DW-1:0] res;
    reg          wr_mem;
    reg          wr_acc;
    reg          set_c;
    reg          new_c;
    reg          all_flags;
    reg          set_z;
    reg          skip;
    reg          tab;
    reg [DW-1:0] bit_mask;
    wire [DW-1:0] m;
    assign m = MEM_RDATA_IN;

    always @* begin
        res       = m;
        wr_mem    = 1'b0;
        wr_acc    = 1'b0;
        set_c     = 1'b0;
        new_c     = CARRY_FLAG_OUT;
        all_flags = 1'b0;
        set_z     = 1'b0;
        skip      = 1'b0;
        tab       = 1'b0;
        bit_mask  = `MRSX_ONE8 << bit_ff;
        case (op_ff)
            `MRSX_OP_RLC, `MRSX_OP_ROTATE_LEFT_VIA_FLAG_TO_WORKING: begin
                res   = {m[DW-2:0], CARRY_FLAG_OUT};   // RULE1
                new_c = m[`MRSX_MSB];
                set_c = 1'b1;
                wr_mem = (op_ff == `MRSX_OP_RLC);
                wr_acc = (op_ff == `MRSX_OP_ROTATE_LEFT_VIA_FLAG_TO_WORKING);
            end
            `MRSX_OP_RR, `MRSX_OP_RRA: begin
                res    = {m[0], m[DW-1:1]};            // RULE2 RULE3
                wr_mem = (op_ff == `MRSX_OP_RR);
                wr_acc = (op_ff == `MRSX_OP_RRA);
            end
            `MRSX_OP_RRC, `MRSX_OP_ROTATE_RIGHT_VIA_FLAG_TO_WORKING: begin
                res    = {CARRY_FLAG_OUT, m[DW-1:1]};  // RULE4 RULE5
                new_c  = m[0];
                set_c  = 1'b1;
                wr_mem = (op_ff == `MRSX_OP_RRC);
                wr_acc = (op_ff == `MRSX_OP_ROTATE_RIGHT_VIA_FLAG_TO_WORKING);
            end
            `MRSX_OP_SBC, `MRSX_OP_SUB, `MRSX_OP_SUBI: begin
                res       = sub_diff;                  // RULE6 RULE15
                wr_acc    = 1'b1;
                all_flags = 1'b1;
            end
            `MRSX_OP_MINUS_WITH_BORROW_TO_MEMORY, `MRSX_OP_MINUS_INTO_MEMORY: begin
                res       = sub_diff;                  // RULE7 RULE16
                wr_mem    = 1'b1;
                all_flags = 1'b1;
            end
            `MRSX_OP_SDZ, `MRSX_OP_DECREMENT_SKIP_ZERO_TO_WORKING: begin
                res    = m - `MRSX_ONE8;               // RULE8
                skip   = (res == `MRSX_ZERO8);
                wr_mem = (op_ff == `MRSX_OP_SDZ);
                wr_acc = (op_ff == `MRSX_OP_DECREMENT_SKIP_ZERO_TO_WORKING);    // RULE9
            end
            `MRSX_OP_SIZ, `MRSX_OP_INCREMENT_SKIP_ZERO_TO_WORKING: begin
                res    = m + `MRSX_ONE8;               // RULE10
                skip   = (res == `MRSX_ZERO8);
                wr_mem = (op_ff == `MRSX_OP_SIZ);
                wr_acc = (op_ff == `MRSX_OP_INCREMENT_SKIP_ZERO_TO_WORKING);    // RULE9
            end
            `MRSX_OP_SETB: begin
                res    = `MRSX_ONES8;                  // RULE12
                wr_mem = 1'b1;
            end
            `MRSX_OP_SETBIT: begin
                res    = m | bit_mask;                 // RULE13
                wr_mem = 1'b1;
            end
            `MRSX_OP_SNZ: begin
                skip = m[bit_ff];                      // RULE14
            end
            `MRSX_OP_SZBIT: begin
                skip = ~m[bit_ff];                     // RULE20
            end
            `MRSX_OP_SWAP, `MRSX_OP_NIBBLE_EXCHANGE_TO_WORKING: begin
                res    = {m[`MRSX_NIB-1:0], m[DW-1:`MRSX_NIB]}; // RULE17
                wr_mem = (op_ff == `MRSX_OP_SWAP);
                wr_acc = (op_ff == `MRSX_OP_NIBBLE_EXCHANGE_TO_WORKING);
            end
            `MRSX_OP_SZ: begin
                skip = (m == `MRSX_ZERO8);             // RULE18
            end
            `MRSX_OP_SZA: begin
                res    = m;                            // RULE19
                wr_acc = 1'b1;
                skip   = (m == `MRSX_ZERO8);
            end
            `MRSX_OP_TABC, `MRSX_OP_TABL: begin
                res    = CODE_RDATA_IN[DW-1:0];        // RULE21
                wr_mem = 1'b1;
                tab    = 1'b1;
            end
            `MRSX_OP_XOR, `MRSX_OP_XORI, `MRSX_OP_EXCLUSIVE_OR_INTO_MEMORY: begin
                res    = WORKING_OUT ^ ((op_ff == `MRSX_OP_XORI) ? imm_ff : m); // RULE22
                set_z  = 1'b1;
                wr_mem = (op_ff == `MRSX_OP_EXCLUSIVE_OR_INTO_MEMORY);
                wr_acc = (op_ff != `MRSX_OP_EXCLUSIVE_OR_INTO_MEMORY);
            end
            default: begin
                res = m;
            end
        endcase
    end

    // ----------------------------------------
    // sequencer: idle, execute, optional dummy cycle
    // ----------------------------------------
    // a taken skip spends one extra cycle so the caller can drop the word
    // it already fetched; no new start is taken until that cycle is over
    always @* begin
        case (state_ff)
            `MRSX_ST_IDLE:  nxt_state = START_IN ? `MRSX_ST_EXEC : `MRSX_ST_IDLE;
            `MRSX_ST_EXEC:  nxt_state = skip ? `MRSX_ST_DUMMY : `MRSX_ST_IDLE; // RULE11
            `MRSX_ST_DUMMY: nxt_state = `MRSX_ST_IDLE;
            default:        nxt_state = `MRSX_ST_IDLE;
        endcase
    end

    // table page: current page keeps upper pc bits, final page forces them high
    wire [AW-1:0] tab_addr_cur;
    wire [AW-1:0] tab_addr_last;
    assign tab_addr_cur  = {PC_IN[AW-1:DW], TABLE_POINTER_IN};
    assign tab_addr_last = {{(AW-DW){1'b1}}, TABLE_POINTER_IN};

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // pulses fall back low on every enabled edge so each lasts one cycle;
    // the data byte is not latched, so it must hold until the exec cycle
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_ff             <= `MRSX_ST_IDLE;
            op_ff                <= 5'h00;
            bit_ff               <= 3'h0;
            imm_ff               <= {DW{1'b0}};
            CODE_ADDR_OUT        <= {AW{1'b0}};
            MEM_WE_OUT           <= 1'b0;
            MEM_WDATA_OUT        <= {DW{1'b0}};
            WORKING_OUT          <= {DW{1'b0}};
            CARRY_FLAG_OUT       <= 1'b0;
            ZERO_FLAG_OUT        <= 1'b0;
            SIGNED_WRAP_FLAG_OUT <= 1'b0;
            HALF_CARRY_FLAG_OUT  <= 1'b0;
            TABLE_HIGH_LATCH_OUT <= {(PW-DW){1'b0}};
            DONE_OUT             <= 1'b0;
            SKIP_OUT             <= 1'b0;
            DUMMY_CYCLE_OUT      <= 1'b0;
            BUSY_OUT             <= 1'b0;
        end else if (CE_IN) begin
            state_ff        <= nxt_state;
            MEM_WE_OUT      <= 1'b0;
            DONE_OUT        <= 1'b0;
            SKIP_OUT        <= 1'b0;
            DUMMY_CYCLE_OUT <= 1'b0;
            BUSY_OUT        <= (nxt_state != `MRSX_ST_IDLE);
            if (state_ff == `MRSX_ST_IDLE && START_IN) begin
                op_ff         <= OPCODE_IN;
                bit_ff        <= BIT_SEL_IN;
                imm_ff        <= IMM_IN;
                CODE_ADDR_OUT <= (OPCODE_IN == `MRSX_OP_TABL) ? tab_addr_last : tab_addr_cur; // RULE21
            end
            if (state_ff == `MRSX_ST_EXEC) begin
                MEM_WE_OUT    <= wr_mem;
                MEM_WDATA_OUT <= res;
                DONE_OUT      <= ~skip;
                SKIP_OUT      <= skip;
                if (wr_acc)
                    WORKING_OUT <= res;
                if (set_c)
                    CARRY_FLAG_OUT <= new_c;
                if (all_flags) begin
                    CARRY_FLAG_OUT       <= sub_c;
                    ZERO_FLAG_OUT        <= sub_z;
                    SIGNED_WRAP_FLAG_OUT <= sub_v;
                    HALF_CARRY_FLAG_OUT  <= sub_h;
                end
                if (set_z)
                    ZERO_FLAG_OUT <= (res == `MRSX_ZERO8); // RULE22
                if (tab)
                    TABLE_HIGH_LATCH_OUT <= CODE_RDATA_IN[PW-1:DW];
            end
            if (state_ff == `MRSX_ST_DUMMY) begin
                DUMMY_CYCLE_OUT <= 1'b1;               // RULE11
                DONE_OUT        <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/mrsx_mem_model.sv
// data byte and program code memory facing the execution datapath
`timescale 1ns/10ps
`default_nettype none
module mrsx_mem_model #(
    parameter DW = 8,
    parameter PW = 15,
    parameter AW = 10
) (
    // clock, reset and bench preload
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          load_in,
    input  wire logic [DW-1:0] load_data_in,
    // datapath side
    input  wire logic          we_in,
    input  wire logic [DW-1:0] wdata_in,
    input  wire logic [AW-1:0] code_addr_in,
    output logic      [DW-1:0] rdata_out,
    output logic      [PW-1:0] code_out
);
    logic [DW-1:0] byte_ff;
    // the byte holds steady through the whole instruction, as the datapath expects
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) byte_ff <= 8'h00;
        else if (load_in) byte_ff <= load_data_in;
        else if (we_in) byte_ff <= wdata_in;
    end
    assign rdata_out = byte_ff;
    // code word depends on every address bit so a wrong page shows up
    assign code_out = {code_addr_in[AW-1:3], code_addr_in[7:0] ^ 8'hA5};
endmodule
`default_nettype wire

// ===== tb/mrsx_exec_properties.sv
// timing and result properties of the execution datapath
`include "mrsx_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module mrsx_exec_properties #(
    parameter DW = 8
) (
    input  wire logic          CLOCK_IN,
    input  wire logic          RST_IN,
    input  wire logic          CE_IN,
    input  wire logic          START_IN,
    input  wire logic [4:0]    OPCODE_IN,
    input  wire logic [DW-1:0] MEM_RDATA_IN,
    input  wire logic          MEM_WE_OUT,
    input  wire logic [DW-1:0] MEM_WDATA_OUT,
    input  wire logic [DW-1:0] WORKING_OUT,
    input  wire logic          CARRY_FLAG_OUT,
    input  wire logic          ZERO_FLAG_OUT,
    input  wire logic          SIGNED_WRAP_FLAG_OUT,
    input  wire logic          HALF_CARRY_FLAG_OUT,
    input  wire logic          DONE_OUT,
    input  wire logic          SKIP_OUT,
    input  wire logic          DUMMY_CYCLE_OUT,
    input  wire logic          BUSY_OUT
);
    logic          iss_ff, res_ff;
    logic [4:0]    op_ff;
    logic [DW-1:0] m_ff, w_ff;
    wire issue = START_IN && CE_IN && !BUSY_OUT;
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) {iss_ff, res_ff} <= 2'h0;
        else if (CE_IN) {iss_ff, res_ff} <= {issue, iss_ff};
    end
    // operands frozen at issue, compared against the result cycle
    always_ff @(posedge CLOCK_IN) begin
        if (issue) {op_ff, m_ff, w_ff} <= {OPCODE_IN, MEM_RDATA_IN, WORKING_OUT};
    end
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_issue; START_IN && CE_IN && !BUSY_OUT; endsequence
    sequence s_dummy; DUMMY_CYCLE_OUT && DONE_OUT && !BUSY_OUT; endsequence
    issue_busy_a: assert property (s_issue |=> BUSY_OUT)
        else $error("busy missing after issue");
    exec_ends_a: assert property (s_issue ##1 CE_IN |=> DONE_OUT || SKIP_OUT)
        else $error("no result one cycle after exec");
    skip_dummy_a: assert property (SKIP_OUT && CE_IN |=> s_dummy)
        else $error("skip without dummy cycle");
    dummy_cause_a: assert property (DUMMY_CYCLE_OUT |-> $past(SKIP_OUT))
        else $error("dummy cycle without skip");
    rot_right_a: assert property (res_ff && op_ff == `MRSX_OP_RR |->
        MEM_WE_OUT && MEM_WDATA_OUT == {m_ff[0], m_ff[7:1]})
        else $error("plain right rotate wrong");
    set_byte_a: assert property (res_ff && op_ff == `MRSX_OP_SETB |-> MEM_WE_OUT && &MEM_WDATA_OUT)
        else $error("set byte wrong");
    xor_mem_a: assert property (res_ff && op_ff == `MRSX_OP_EXCLUSIVE_OR_INTO_MEMORY |->
        MEM_WDATA_OUT == (w_ff ^ m_ff) && ZERO_FLAG_OUT == (w_ff == m_ff))
        else $error("xor into memory wrong");
    keep_mem_a: assert property (res_ff && op_ff inside {`MRSX_OP_DECREMENT_SKIP_ZERO_TO_WORKING, `MRSX_OP_INCREMENT_SKIP_ZERO_TO_WORKING, `MRSX_OP_RRA,
        `MRSX_OP_ROTATE_LEFT_VIA_FLAG_TO_WORKING, `MRSX_OP_ROTATE_RIGHT_VIA_FLAG_TO_WORKING, `MRSX_OP_NIBBLE_EXCHANGE_TO_WORKING, `MRSX_OP_SZA} |-> !MEM_WE_OUT)
        else $error("working form wrote memory");
    flags_kept_a: assert property (res_ff && op_ff inside {`MRSX_OP_RR, `MRSX_OP_SDZ, `MRSX_OP_SIZ,
        `MRSX_OP_SETB, `MRSX_OP_SWAP, `MRSX_OP_SZ} |-> $stable({CARRY_FLAG_OUT, ZERO_FLAG_OUT,
        SIGNED_WRAP_FLAG_OUT, HALF_CARRY_FLAG_OUT}))
        else $error("flags changed by flag-free op");
    inc_skip_a: assert property (res_ff && op_ff == `MRSX_OP_SIZ |-> SKIP_OUT == (&m_ff))
        else $error("increment skip wrong");
    ce_freeze_a: assert property (!CE_IN |=> $stable({WORKING_OUT, MEM_WE_OUT, DONE_OUT, SKIP_OUT, BUSY_OUT,
        CARRY_FLAG_OUT, ZERO_FLAG_OUT}))
        else $error("state moved with clock enable low");
endmodule
bind mrsx_exec mrsx_exec_properties #(.DW(DW)) u_props (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
    .CE_IN(CE_IN), .START_IN(START_IN), .OPCODE_IN(OPCODE_IN), .MEM_RDATA_IN(MEM_RDATA_IN),
    .MEM_WE_OUT(MEM_WE_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT), .WORKING_OUT(WORKING_OUT),
    .CARRY_FLAG_OUT(CARRY_FLAG_OUT), .ZERO_FLAG_OUT(ZERO_FLAG_OUT), .SIGNED_WRAP_FLAG_OUT(SIGNED_WRAP_FLAG_OUT),
    .HALF_CARRY_FLAG_OUT(HALF_CARRY_FLAG_OUT), .DONE_OUT(DONE_OUT), .SKIP_OUT(SKIP_OUT),
    .DUMMY_CYCLE_OUT(DUMMY_CYCLE_OUT), .BUSY_OUT(BUSY_OUT));
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the execution datapath
`include "mrsx_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 0, rst = 1, ld = 0, start = 0, ce = 1, we, dn, sk, dm, by, cf, zf, of, hf;
    logic [4:0] op = 0;
    logic [2:0] bs = 0;
    logic [7:0] imm = 0, ldv = 0, mrd, wd, w, w_e, tp = 8'h34;
    logic [9:0] ca, pc = 10'h2C5;
    logic [14:0] crd;
    logic [6:0] th;
    logic c_e, z_e, o_e, h_e;
    int err_total = 0, n_compared = 0;
    localparam logic [7:0] PAT = 8'h5A;
    always #5 clk = ~clk;
    mrsx_exec u_mrsx_exec (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(ce), .START_IN(start), .OPCODE_IN(op),
        .BIT_SEL_IN(bs), .IMM_IN(imm), .MEM_RDATA_IN(mrd), .TABLE_POINTER_IN(tp), .PC_IN(pc),
        .CODE_RDATA_IN(crd), .CODE_ADDR_OUT(ca), .MEM_WE_OUT(we), .MEM_WDATA_OUT(wd), .WORKING_OUT(w),
        .CARRY_FLAG_OUT(cf), .ZERO_FLAG_OUT(zf), .SIGNED_WRAP_FLAG_OUT(of), .HALF_CARRY_FLAG_OUT(hf),
        .TABLE_HIGH_LATCH_OUT(th), .DONE_OUT(dn), .SKIP_OUT(sk), .DUMMY_CYCLE_OUT(dm), .BUSY_OUT(by));
    mrsx_mem_model u_mrsx_mem_model (.clk_in(clk), .rst_in(rst), .load_in(ld), .load_data_in(ldv),
        .we_in(we), .wdata_in(wd), .code_addr_in(ca), .rdata_out(mrd), .code_out(crd));
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task finish_test;
        $display("errors %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // preload the byte, issue one op, gather the result and skip pulses
    task run(input logic [4:0] o, input logic [2:0] b, input logic [7:0] m, input logic [7:0] x,
             input logic ewe, input logic [7:0] ewd, input logic esk);
        logic gw, gs, gd, gdn;
        logic [7:0] gwd;
        @(negedge clk);
        ld = 1;
        ldv = m;
        @(negedge clk);
        {ld, start, op, bs, imm} = {1'b0, 1'b1, o, b, x};
        {gw, gs, gd, gdn, gwd} = 12'h000;
        @(negedge clk);
        start = 0;
        repeat (4) begin
            if (!gdn) begin
                @(negedge clk);
                if (we) {gw, gwd} = {1'b1, wd};
                if (sk) gs = 1;
                if (dn) {gdn, gd} = {1'b1, dm};
            end
        end
        chk({gdn, w, cf, zf, of, hf}, {1'b1, w_e, c_e, z_e, o_e, h_e});
        chk({gw, gwd, gs, gd}, {ewe, ewe ? ewd : 8'h00, esk, esk});
    endtask
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        {w_e, c_e, z_e, o_e, h_e} = 12'h000;
        repeat (12) @(negedge clk);
        rst = 0;
        run(`MRSX_OP_SZA, 0, 8'h00, 0, 0, 0, 1);
        w_e = 8'h96; run(`MRSX_OP_SZA, 0, 8'h96, 0, 0, 0, 0);
        c_e = 1; run(`MRSX_OP_RLC, 0, 8'h81, 0, 1, 8'h02, 0);
        w_e = 8'h81; c_e = 0; run(`MRSX_OP_ROTATE_LEFT_VIA_FLAG_TO_WORKING, 0, 8'h40, 0, 0, 0, 0);
        run(`MRSX_OP_RR, 0, 8'h01, 0, 1, 8'h80, 0);
        w_e = 8'h82; run(`MRSX_OP_RRA, 0, 8'h05, 0, 0, 0, 0);
        c_e = 1; run(`MRSX_OP_RRC, 0, 8'h01, 0, 1, 8'h00, 0);
        w_e = 8'h81; c_e = 0; run(`MRSX_OP_ROTATE_RIGHT_VIA_FLAG_TO_WORKING, 0, 8'h02, 0, 0, 0, 0);
        w_e = 8'h10; run(`MRSX_OP_SZA, 0, 8'h10, 0, 0, 0, 0);
        w_e = 8'hF0; h_e = 1; run(`MRSX_OP_SUB, 0, 8'h20, 0, 0, 0, 0);
        w_e = 8'hE0; {c_e, h_e} = 2'h2; run(`MRSX_OP_SBC, 0, 8'h0F, 0, 0, 0, 0);
        {z_e, h_e} = 2'h3; run(`MRSX_OP_MINUS_WITH_BORROW_TO_MEMORY, 0, 8'hE0, 0, 1, 8'h00, 0);
        w_e = 8'h7F; {z_e, o_e, h_e} = 3'h2; run(`MRSX_OP_SUBI, 0, 0, 8'h61, 0, 0, 0);
        {c_e, h_e} = 2'h1; run(`MRSX_OP_MINUS_INTO_MEMORY, 0, 8'h80, 0, 1, 8'hFF, 0);
        run(`MRSX_OP_SDZ, 0, 8'h01, 0, 1, 8'h00, 1);
        run(`MRSX_OP_SDZ, 0, 8'h05, 0, 1, 8'h04, 0);
        run(`MRSX_OP_SIZ, 0, 8'hFF, 0, 1, 8'h00, 1);
        run(`MRSX_OP_SIZ, 0, 8'h7F, 0, 1, 8'h80, 0);
        w_e = 8'h00; run(`MRSX_OP_INCREMENT_SKIP_ZERO_TO_WORKING, 0, 8'hFF, 0, 0, 0, 1);
        w_e = 8'h01; run(`MRSX_OP_DECREMENT_SKIP_ZERO_TO_WORKING, 0, 8'h02, 0, 0, 0, 0);
        run(`MRSX_OP_SETB, 0, 8'h12, 0, 1, 8'hFF, 0);
        for (int i = 0; i < 8; i++) begin
            run(`MRSX_OP_SETBIT, i, PAT, 0, 1, PAT | (8'h01 << i), 0);
            run(`MRSX_OP_SNZ, i, PAT, 0, 0, 0, PAT[i]);
            run(`MRSX_OP_SZBIT, i, PAT, 0, 0, 0, !PAT[i]);
        end
        run(`MRSX_OP_SWAP, 0, 8'h3C, 0, 1, 8'hC3, 0);
        w_e = 8'h5A; run(`MRSX_OP_NIBBLE_EXCHANGE_TO_WORKING, 0, 8'hA5, 0, 0, 0, 0);
        run(`MRSX_OP_SZ, 0, 8'h00, 0, 0, 0, 1);
        run(`MRSX_OP_SZ, 0, 8'h01, 0, 0, 0, 0);
        run(`MRSX_OP_TABC, 0, 8'h00, 0, 1, 8'h91, 0);
        chk({ca, th}, {10'h234, 7'h46});
        run(`MRSX_OP_TABL, 0, 8'h00, 0, 1, 8'h91, 0);
        chk({ca, th}, {10'h334, 7'h66});
        w_e = 8'h00; z_e = 1; run(`MRSX_OP_XOR, 0, 8'h5A, 0, 0, 0, 0);
        w_e = 8'h3C; z_e = 0; run(`MRSX_OP_XORI, 0, 8'hFF, 8'h3C, 0, 0, 0);
        z_e = 1; run(`MRSX_OP_EXCLUSIVE_OR_INTO_MEMORY, 0, 8'h3C, 0, 1, 8'h00, 0);
        {tp, pc} = {8'hCB, 10'h13A};
        run(`MRSX_OP_TABC, 0, 8'h00, 0, 1, 8'h6E, 0);
        chk({ca, th}, {10'h1CB, 7'h39});
        // clock enable low: a start is ignored, then a running swap holds still
        ld = 1;
        ldv = 8'h3C;
        @(negedge clk);
        {ld, ce, start, op} = {1'b0, 1'b0, 1'b1, `MRSX_OP_SWAP};
        repeat (2) @(negedge clk);
        chk({by, we, dn}, 3'h0);
        ce = 1;
        @(negedge clk);
        {ce, start} = 2'h0;
        repeat (3) @(negedge clk);
        chk({by, we, dn}, 3'h4);
        ce = 1;
        @(negedge clk);
        chk({by, we, wd, dn}, {1'b0, 1'b1, 8'hC3, 1'b1});
        finish_test;
    end
    // about 60 ops of at most 8 cycles each; ten times that cuts a hang short
    initial begin
        #50000;
        err_total++;
        finish_test;
    end
endmodule
`default_nettype wire
